// ---- src/pdg_i2c_target.sv ----
// I2C target that acknowledges one address and returns a status byte
`timescale 1ns/1ps
module pdg_i2c_target
   import pdg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl_sync,
   input wire logic sda_sync,
   input wire logic [7:0] status_byte,
   output logic sda_oe,
   output logic read_done
);
   // Protocol phases
   typedef enum {
      PDG_IDLE,
      PDG_ADDR,
      PDG_AACK,
      PDG_SEND,
      PDG_MACK
   } pdg_i2c_t;
   pdg_i2c_t state;
   logic scl_d; // Previous clock level for edges
   logic sda_d; // Previous data level for start and stop
   logic [3:0] bit_cnt; // Bits seen in the current byte
   logic [7:0] shift; // Address in, data out
   wire scl_rise = scl_sync & ~scl_d;
   wire scl_fall = ~scl_sync & scl_d;
   wire start_seen = scl_sync & sda_d & ~sda_sync;
   wire stop_seen = scl_sync & ~sda_d & sda_sync;
   // Address match on the seven upper bits, read direction only
   wire addr_hit = (shift[7:1] == I2C_ADDR) && shift[0];

   // Edge history
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_sync;
         sda_d <= sda_sync;
      end
   end

   // Phase machine; start and stop override any phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= PDG_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         sda_oe <= 1'b0;
         read_done <= 1'b0;
      end else begin
         read_done <= 1'b0;
         if (start_seen) begin
            state <= PDG_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_seen) begin
            state <= PDG_IDLE;
            sda_oe <= 1'b0;
         end else begin
            unique case (state)
               PDG_IDLE: begin
                  sda_oe <= 1'b0;
               end
               PDG_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_sync};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (scl_fall && bit_cnt == BIT_LAST) begin
                     // Ack only our own address
                     if (addr_hit) begin
                        sda_oe <= 1'b1;
                        state <= PDG_AACK;
                     end else begin
                        state <= PDG_IDLE;
                     end
                  end
               end
               PDG_AACK: begin
                  if (scl_fall) begin
                     // Load status and put its first bit out
                     shift <= status_byte;
                     sda_oe <= ~status_byte[7];
                     bit_cnt <= 4'h1;
                     state <= PDG_SEND;
                  end
               end
               PDG_SEND: begin
                  if (scl_fall) begin
                     if (bit_cnt == BIT_LAST) begin
                        sda_oe <= 1'b0;
                        state <= PDG_MACK;
                     end else begin
                        sda_oe <= ~shift[6];
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               PDG_MACK: begin
                  if (scl_rise) begin
                     read_done <= 1'b1;
                     // A nack ends the read; an ack repeats the byte
                     state <= sda_sync ? PDG_IDLE : PDG_AACK;
                  end
               end
            endcase
         end
      end
   end
endmodule

// ---- src/pdg_pkg.sv ----
// Package of constants and types for the port system glue block
package pdg_pkg;
   // Clock rate and the least settle time after companion supply good
   localparam int CLK_MHZ = 100;
   localparam int SUPPLY_SETTLE_US = 100;
   localparam int SETTLE_CYCLES = SUPPLY_SETTLE_US * CLK_MHZ;
   localparam int SETTLE_W = 14;
   // I2C target address of the status port
   localparam logic [6:0] I2C_ADDR = 7'h38;
   // Connection kinds reported by the policy logic
   typedef enum logic [1:0] {
      PDG_CONN_NONE,
      PDG_CONN_USB,
      PDG_CONN_ALT,
      PDG_CONN_LINK
   } pdg_conn_t;
   // Power object fields: voltage in 50 mV units, current in 10 mA units
   localparam logic [9:0] PDO_5V = 10'h064;
   localparam logic [9:0] PDO_9V = 10'h0B4;
   localparam logic [9:0] PDO_15V = 10'h12C;
   localparam logic [9:0] PDO_20V = 10'h190;
   localparam logic [9:0] PDO_1A5 = 10'h096;
   localparam logic [9:0] PDO_3A = 10'h12C;
   localparam logic [9:0] PDO_5A = 10'h1F4;
   // Fixed supply type code in the top two bits
   localparam logic [1:0] PDO_FIXED = 2'h0;
   localparam int PDO_V_LSB = 10;
   // Display pin assignment mask: C, D, E
   localparam logic [5:0] PIN_ASSIGN_CDE = 6'h1C;
   // Status byte bit positions
   localparam int ST_ORIENT = 0;
   localparam int ST_USB3 = 1;
   localparam int ST_ALT = 2;
   localparam int ST_LINK = 3;
   localparam int ST_ATTACH = 4;
   localparam int ST_HOST = 5;
   localparam int ST_SRC_FACING = 6;
   // I2C shift register widths
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_LAST = 4'h8;
endpackage

// ---- src/pdg_port_glue.sv ----
// System glue of a single-port power-delivery controller
//
// Contract
// - Companion held in reset until configuration loaded
// - Flash used by us first, companion after
// - First GPIO is dedicated active-low companion reset
// - Release reset 100 us after supply good
// - Interrupt companion after connection kind determined
// - I2C target always on, acknowledges address 0x38 (acked only with the read direction bit set; a write to 0x38 gets a nack)
// - Drive orientation, USB3, altmode to high-speed mux
// - Drive sideband mux selects and path enables
// - USB-display build: one source 5 V 1.5 A
// - Companion build: one source 5 V 3 A
// - Four sink objects 5/9/15/20 V, 3 A; 20 V object at 5 A when sink_20v_5a is set
// - USB host, display source-facing, pins C/D/E
`timescale 1ns/1ps
module pdg_port_glue
   import pdg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cfg_loaded,
   input wire logic companion_build,
   input wire logic sink_20v_5a,
   input wire logic companion_supply_good,
   input wire logic host_embedded_ctl_own,
   input wire logic host_embedded_ctl_release,
   input wire logic conn_valid,
   input wire logic [1:0] conn_kind,
   input wire logic conn_flip,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic companion_rst_line,
   output logic flash_grant_companion,
   output logic companion_irq,
   output logic mux_flip,
   output logic usb3_select,
   output logic altmode_select,
   output logic sideband_a_orient,
   output logic sideband_b_orient,
   output logic aux_path_enable,
   output logic link_sideband_enable,
   output logic [1:0] src_pdo_count,
   output logic [31:0] src_pdo0,
   output logic [2:0] snk_pdo_count,
   output logic [31:0] snk_pdo0,
   output logic [31:0] snk_pdo1,
   output logic [31:0] snk_pdo2,
   output logic [31:0] snk_pdo3,
   output logic usb_data_host,
   output logic display_source_facing,
   output logic [5:0] display_pin_assign
);
   // Builds a fixed power object from voltage and current fields
   function automatic logic [31:0] pdg_fixed(input logic [9:0] volts,
                                             input logic [9:0] amps);
      pdg_fixed = {PDO_FIXED, 10'h000, volts, amps};
   endfunction

   // Two-flop synchronisers for pins from outside the domain
   logic sg_m, sg_s; // Supply good
   logic scl_m, scl_s; // I2C clock
   logic sda_m, sda_s; // I2C data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sg_m <= 1'b0;
         sg_s <= 1'b0;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sg_m <= companion_supply_good;
         sg_s <= sg_m;
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
      end
   end

   // Reset sequencer: the release waits on both the config load and
   // a settled supply, so a late supply never sees an early release
   typedef enum {
      PDG_LOAD,
      PDG_WAIT_SUPPLY,
      PDG_SETTLE,
      PDG_RUN
   } pdg_seq_t;
   pdg_seq_t seq, next_seq;
   logic [SETTLE_W-1:0] settle_cnt; // Cycles of good supply
   wire settle_done = settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1);

   always_comb begin
      next_seq = seq;
      unique case (seq)
         PDG_LOAD:
            if (cfg_loaded) next_seq = PDG_WAIT_SUPPLY;
         PDG_WAIT_SUPPLY:
            if (sg_s) next_seq = PDG_SETTLE;
         PDG_SETTLE:
            if (!sg_s) next_seq = PDG_WAIT_SUPPLY;
            else if (settle_done) next_seq = PDG_RUN;
         PDG_RUN:
            if (!sg_s) next_seq = PDG_WAIT_SUPPLY;
      endcase
   end

   // Sequencer state and settle counter
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seq <= PDG_LOAD;
         settle_cnt <= '0;
      end else begin
         seq <= next_seq;
         if (seq == PDG_SETTLE && !settle_done)
            settle_cnt <= settle_cnt + SETTLE_W'(1);
         else if (seq != PDG_SETTLE)
            settle_cnt <= '0;
      end
   end

   // Release allowed by sequencer; the host override waits for the
   // settle too, and both paths drop as soon as the supply goes away
   wire seq_release = seq == PDG_RUN && sg_s;
   wire host_release = host_embedded_ctl_release & seq_release;
   wire loaded = seq != PDG_LOAD;
   wire release_ok = loaded &&
                     (host_embedded_ctl_own ? host_release : seq_release);

   // Pin 0 drives nothing but the companion reset, low while held
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         companion_rst_line <= 1'b0;
         flash_grant_companion <= 1'b0;
      end else begin
         companion_rst_line <= release_ok;
         flash_grant_companion <= loaded;
      end
   end

   // Mux control decode from the connection event
   wire is_usb = conn_valid && (conn_kind == PDG_CONN_USB ||
                                conn_kind == PDG_CONN_ALT);
   wire is_alt = conn_valid && conn_kind == PDG_CONN_ALT;
   wire is_link = conn_valid && conn_kind == PDG_CONN_LINK;
   wire flip = conn_valid & conn_flip;

   // Registered mux outputs so the pins never glitch on decode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mux_flip <= 1'b0;
         usb3_select <= 1'b0;
         altmode_select <= 1'b0;
         sideband_a_orient <= 1'b0;
         sideband_b_orient <= 1'b0;
         aux_path_enable <= 1'b0;
         link_sideband_enable <= 1'b0;
      end else begin
         mux_flip <= flip;
         usb3_select <= is_usb;
         altmode_select <= is_alt;
         sideband_a_orient <= flip;
         sideband_b_orient <= flip;
         aux_path_enable <= is_alt;
         link_sideband_enable <= is_link;
      end
   end

   // Status byte that the companion reads
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[ST_ORIENT] = flip;
      status[ST_USB3] = is_usb;
      status[ST_ALT] = is_alt;
      status[ST_LINK] = is_link;
      status[ST_ATTACH] = conn_valid;
      status[ST_HOST] = 1'b1;
      status[ST_SRC_FACING] = 1'b1;
   end

   // Interrupt: raised on any change of the determined connection,
   // dropped once the companion has read the status; a new change in
   // the same cycle as the read keeps it raised
   logic [7:0] status_seen;
   logic read_done;
   wire status_change = status != status_seen;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_seen <= 8'h00;
         companion_irq <= 1'b0;
      end else begin
         status_seen <= status;
         if (status_change)
            companion_irq <= 1'b1;
         else if (read_done)
            companion_irq <= 1'b0;
      end
   end

   // I2C target is never gated by reset sequencing or mode
   pdg_i2c_target u_i2c (
      .sys_clk(sys_clk),
      .rst(rst),
      .scl_sync(scl_s),
      .sda_sync(sda_s),
      .status_byte(status),
      .sda_oe(sda_oe),
      .read_done(read_done)
   );
   assign sda_out = 1'b0; // Open drain: only pulls low

   // Advertised capabilities; source picked by build, top sink current by sink_20v_5a
   wire [31:0] src_obj = companion_build ?
                         pdg_fixed(PDO_5V, PDO_3A) :
                         pdg_fixed(PDO_5V, PDO_1A5);
   wire [9:0] top_amps = sink_20v_5a ? PDO_5A : PDO_3A;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_pdo_count <= 2'h0;
         src_pdo0 <= 32'h0000_0000;
         snk_pdo_count <= 3'h0;
         snk_pdo0 <= 32'h0000_0000;
         snk_pdo1 <= 32'h0000_0000;
         snk_pdo2 <= 32'h0000_0000;
         snk_pdo3 <= 32'h0000_0000;
         usb_data_host <= 1'b0;
         display_source_facing <= 1'b0;
         display_pin_assign <= 6'h00;
      end else begin
         src_pdo_count <= 2'h1;
         src_pdo0 <= src_obj;
         snk_pdo_count <= 3'h4;
         snk_pdo0 <= pdg_fixed(PDO_5V, PDO_3A);
         snk_pdo1 <= pdg_fixed(PDO_9V, PDO_3A);
         snk_pdo2 <= pdg_fixed(PDO_15V, PDO_3A);
         snk_pdo3 <= pdg_fixed(PDO_20V, top_amps);
         usb_data_host <= 1'b1;
         display_source_facing <= 1'b1;
         display_pin_assign <= PIN_ASSIGN_CDE;
      end
   end

   // Helper: cycles since supply good last became stable
   logic [SETTLE_W:0] good_run;
   always_ff @(posedge sys_clk) begin
      if (rst || !sg_s) good_run <= '0;
      else if (!(&good_run)) good_run <= good_run + (SETTLE_W+1)'(1);
   end

   sequence s_released;
      $rose(companion_rst_line);
   endsequence

   // Host owns the pin and has not asked for release yet
   sequence s_host_hold;
      host_embedded_ctl_own && !host_embedded_ctl_release;
   endsequence

   a_no_early_release: assert property (
      @(posedge sys_clk) disable iff (rst)
      s_released |-> good_run >= (SETTLE_W+1)'(SETTLE_CYCLES))
      else $error("companion reset released too early");
   a_hold_until_load: assert property (
      @(posedge sys_clk) disable iff (rst)
      $past(seq) == PDG_LOAD |-> !companion_rst_line)
      else $error("reset released before config load");
   a_supply_gates: assert property (
      @(posedge sys_clk) disable iff (rst)
      !sg_s ##1 1'b1 |-> !companion_rst_line)
      else $error("reset released without supply");
   a_host_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      s_host_hold |=> !companion_rst_line)
      else $error("reset released while host holds it");
   a_flash_order: assert property (
      @(posedge sys_clk) disable iff (rst)
      companion_rst_line |-> flash_grant_companion)
      else $error("companion runs before flash handover");
   a_irq_on_change: assert property (
      @(posedge sys_clk) disable iff (rst)
      status_change |=> companion_irq)
      else $error("interrupt missing after connection change");
   a_mux_follow: assert property (
      @(posedge sys_clk) disable iff (rst)
      1'b1 |=> usb3_select == $past(is_usb) &&
               altmode_select == $past(is_alt) &&
               mux_flip == $past(flip))
      else $error("high-speed mux outputs stale");
   a_sideband_pair: assert property (
      @(posedge sys_clk) disable iff (rst)
      sideband_a_orient == sideband_b_orient &&
      aux_path_enable == altmode_select)
      else $error("sideband selects disagree");
   a_src_cap: assert property (
      @(posedge sys_clk) disable iff (rst)
      $past(companion_build) ##0 !$rose(src_pdo_count[0])
      |-> src_pdo0[9:0] == PDO_3A || src_pdo_count == 2'h0)
      else $error("wrong source capability");
   // A build change reaches the source object one edge later, so the
   // build is taken from the previous edge
   a_src_usb: assert property (
      @(posedge sys_clk) disable iff (rst)
      !$past(companion_build) ##0 !$rose(src_pdo_count[0])
      |-> src_pdo0[9:0] == PDO_1A5 || src_pdo_count == 2'h0)
      else $error("wrong source capability for usb build");
   // The raised top sink current follows its strap one edge late
   a_sink_top: assert property (
      @(posedge sys_clk) disable iff (rst)
      snk_pdo_count == 3'h4 |->
      snk_pdo3[9:0] == ($past(sink_20v_5a) ? PDO_5A : PDO_3A))
      else $error("wrong top sink capability");
endmodule

// ---- testbench/pdg_companion_model.sv ----
// Behavioural companion controller: an I2C master that reads status
`timescale 1ns/1ps
module pdg_companion_model #(
   parameter int HALF = 20
) (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [6:0] addr,
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull,
   output logic busy,
   output logic acked,
   output logic [7:0] rd_byte
);
   // Wait a number of system clocks
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Data moves only mid-low, so it never mimics a start or a stop
   task automatic put_bit(input logic b);
      hold(HALF / 2);
      sda_pull <= ~b;
      hold(HALF / 2);
      scl <= 1'b1;
      hold(HALF);
      scl <= 1'b0;
   endtask
   // Release the line and sample it in the middle of the high phase
   task automatic get_bit(output logic b);
      hold(HALF / 2);
      sda_pull <= 1'b0;
      hold(HALF / 2);
      scl <= 1'b1;
      hold(HALF / 2);
      b = sda_line;
      hold(HALF / 2);
      scl <= 1'b0;
   endtask
   // One read transfer per request: start, address, byte, nack, stop
   initial begin
      logic b;
      scl = 1'b1;
      sda_pull = 1'b0;
      busy = 1'b0;
      acked = 1'b0;
      rd_byte = 8'h00;
      forever begin
         @(posedge sys_clk);
         if (go) begin
            busy <= 1'b1;
            sda_pull <= 1'b1;
            hold(HALF);
            scl <= 1'b0;
            // Address first, then the read direction bit
            for (int i = 6; i >= 0; i--) begin
               put_bit(addr[i]);
            end
            put_bit(1'b1);
            get_bit(b);
            acked <= ~b;
            // Status byte, most significant bit first
            for (int i = 7; i >= 0; i--) begin
               get_bit(b);
               rd_byte[i] <= b;
            end
            // Nack ends the read, then a stop
            put_bit(1'b1);
            hold(HALF / 2);
            sda_pull <= 1'b1;
            hold(HALF / 2);
            scl <= 1'b1;
            hold(HALF);
            sda_pull <= 1'b0;
            hold(HALF);
            busy <= 1'b0;
         end
      end
   end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the port system glue block
`timescale 1ns/1ps
module testbench;
   import pdg_pkg::*;
   // Design inputs
   logic sys_clk, rst, cfg_loaded, companion_build, sink_20v_5a;
   logic companion_supply_good, host_embedded_ctl_own;
   logic host_embedded_ctl_release, conn_valid, conn_flip;
   logic [1:0] conn_kind;
   // Design outputs
   logic sda_out, sda_oe, companion_rst_line, flash_grant_companion;
   logic companion_irq, mux_flip, usb3_select, altmode_select;
   logic sideband_a_orient, sideband_b_orient, aux_path_enable;
   logic link_sideband_enable, usb_data_host, display_source_facing;
   logic [1:0] src_pdo_count;
   logic [2:0] snk_pdo_count;
   logic [31:0] src_pdo0, snk_pdo0, snk_pdo1, snk_pdo2, snk_pdo3;
   logic [5:0] display_pin_assign;
   // Companion model side; SDA has a pull-up, so released reads high
   logic m_go, m_scl, m_pull, m_busy, m_acked, sda_wire;
   logic [6:0] m_addr;
   logic [7:0] m_byte;
   int failures = 0;
   int compares = 0;
   assign sda_wire = !(sda_oe | m_pull);

   pdg_port_glue u_dut (.sys_clk, .rst, .cfg_loaded, .companion_build,
      .sink_20v_5a, .companion_supply_good, .host_embedded_ctl_own,
      .host_embedded_ctl_release, .conn_valid, .conn_kind, .conn_flip,
      .scl_in(m_scl), .sda_in(sda_wire), .sda_out, .sda_oe,
      .companion_rst_line, .flash_grant_companion, .companion_irq,
      .mux_flip, .usb3_select, .altmode_select, .sideband_a_orient,
      .sideband_b_orient, .aux_path_enable, .link_sideband_enable,
      .src_pdo_count, .src_pdo0, .snk_pdo_count, .snk_pdo0, .snk_pdo1,
      .snk_pdo2, .snk_pdo3, .usb_data_host, .display_source_facing,
      .display_pin_assign);

   pdg_companion_model #(.HALF(20)) u_comp (.sys_clk, .go(m_go),
      .addr(m_addr), .sda_line(sda_wire), .scl(m_scl), .sda_pull(m_pull),
      .busy(m_busy), .acked(m_acked), .rd_byte(m_byte));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Compare one result and count it
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic conclude;
      if (failures == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Select a watched output by number
   function automatic logic sig(input int s);
      case (s)
         0: return companion_rst_line;
         1: return companion_irq;
         default: return m_busy;
      endcase
   endfunction
   // Bounded wait for a level; running out ends the run as a failure
   task automatic await(input int s, input logic v, input int lim,
                        output int n);
      for (n = 0; sig(s) !== v; n++) begin
         if (n == lim) begin
            failures++;
            conclude();
         end
         @(posedge sys_clk);
         #1;
      end
   endtask
   // Expected power object from package fields
   function automatic logic [31:0] pdo(input logic [9:0] v, a);
      return {PDO_FIXED, 10'h000, v, a};
   endfunction

   // Release sequence: load, refused host release, settle, supply loss
   task automatic sc_seq;
      int n;
      @(posedge sys_clk);
      host_embedded_ctl_own <= 1'b1;
      host_embedded_ctl_release <= 1'b1;
      tick(30);
      #1;
      check(companion_rst_line, 0);
      check(flash_grant_companion, 0);
      @(posedge sys_clk);
      cfg_loaded <= 1'b1;
      tick(30);
      #1;
      check(flash_grant_companion, 1);
      check(companion_rst_line, 0);
      @(posedge sys_clk);
      host_embedded_ctl_own <= 1'b0;
      host_embedded_ctl_release <= 1'b0;
      companion_supply_good <= 1'b1;
      await(0, 1'b1, 10100, n);
      check(n inside {[SETTLE_CYCLES:SETTLE_CYCLES + 8]}, 1);
      @(posedge sys_clk);
      host_embedded_ctl_own <= 1'b1;
      tick(2);
      #1;
      check(companion_rst_line, 0);
      @(posedge sys_clk);
      host_embedded_ctl_release <= 1'b1;
      tick(2);
      #1;
      check(companion_rst_line, 1);
      @(posedge sys_clk);
      companion_supply_good <= 1'b0;
      await(0, 1'b0, 6, n);
   endtask

   // Capability outputs for both builds
   task automatic sc_caps;
      for (int b = 0; b < 2; b++) begin
         @(posedge sys_clk);
         companion_build <= b[0];
         sink_20v_5a <= b[0];
         tick(2);
         #1;
         check(src_pdo_count, 1);
         check(src_pdo0, pdo(PDO_5V, b[0] ? PDO_3A : PDO_1A5));
         check(snk_pdo_count, 4);
         check(snk_pdo0, pdo(PDO_5V, PDO_3A));
         check(snk_pdo1, pdo(PDO_9V, PDO_3A));
         check(snk_pdo2, pdo(PDO_15V, PDO_3A));
         check(snk_pdo3, pdo(PDO_20V, b[0] ? PDO_5A : PDO_3A));
         check({usb_data_host, display_source_facing, display_pin_assign},
               {2'b11, PIN_ASSIGN_CDE});
      end
   endtask

   // Every connection kind in both orientations
   task automatic sc_mux;
      for (int k = 0; k < 4; k++) begin
         for (int f = 0; f < 2; f++) begin
            @(posedge sys_clk);
            conn_valid <= 1'b1;
            conn_kind <= k[1:0];
            conn_flip <= f[0];
            tick(1);
            #1;
            check({mux_flip, usb3_select, altmode_select},
                  {f[0], k == 1 || k == 2, k == 2});
            check({sideband_a_orient, sideband_b_orient, aux_path_enable,
                   link_sideband_enable},
                  {f[0], f[0], k == 2, k == 3});
         end
      end
   endtask

   // One read by the companion; attach bit is masked out
   task automatic rd(input logic [6:0] a, input logic ack,
                     input logic [7:0] exp);
      int n;
      @(posedge sys_clk);
      m_addr <= a;
      m_go <= 1'b1;
      tick(1);
      m_go <= 1'b0;
      #1;
      await(2, 1'b0, 3000, n);
      check(m_acked, ack);
      if (ack) begin
         check(m_byte & 8'hEF, exp);
      end else begin
         check(m_byte, 8'hFF);
      end
   endtask

   // Interrupt raised on a new status, cleared by the read
   task automatic sc_irq;
      int n;
      rd(I2C_ADDR, 1'b1, 8'h69);
      check(companion_irq, 0);
      @(posedge sys_clk);
      conn_kind <= 2'h2;
      conn_flip <= 1'b0;
      await(1, 1'b1, 2, n);
      rd(I2C_ADDR, 1'b1, 8'h66);
      check(companion_irq, 0);
      rd(I2C_ADDR + 7'h01, 1'b0, 8'h00);
   endtask

   // Main sequence
   initial begin
      {rst, cfg_loaded, companion_build, sink_20v_5a} = 4'hB;
      {companion_supply_good, host_embedded_ctl_own} = 2'h0;
      {host_embedded_ctl_release, conn_valid, conn_flip} = 3'h0;
      conn_kind = 2'h0;
      m_go = 1'b0;
      m_addr = I2C_ADDR;
      cfg_loaded = 1'b0;
      tick(2);
      #1;
      check(companion_rst_line, 0);
      check(sda_oe, 0);
      check(sda_out, 0);
      tick(2);
      rst <= 1'b0;
      tick(1);
      #1;
      check(companion_rst_line, 0);
      sc_seq();
      sc_caps();
      sc_mux();
      sc_irq();
      conclude();
   end
endmodule
